// ==== design/rpds_top.sv ====
// Per-pipe descriptor state with byte access and pipe control outputs
// How it works
// RQ1 - Hold next data sequence, apply to sends
// RQ2 - Keep 32-bit window for sequence tracking
// RQ3 - Maximum sequence accepts only one to 31
// RQ4 - Interval is polling or service interval
// RQ5 - Isochronous pipes poll at air interval
// RQ6 - Host zeroes air interval for non-isochronous
// RQ7 - Decode transfer type from attribute bits
// RQ8 - Attribute bits four to two: transmit power
// RQ9 - Attribute bits seven to five: preamble policy
// RQ10 - Read-only supported types, upper bits zero
// RQ11 - Retry up to limit, then fail
// RQ12 - Limit zero means unlimited, uncounted retries
// RQ13 - Host sets limit zero for isochronous
// RQ14 - Low power bit ignores retry limit
// RQ15 - Count every transaction error, 16 bits
// RQ16 - Host clears the error counter
// RQ17 - Writable fields take writes, read-only keep
// RQ18 - Notify on beacon adjust change, device notice
// RQ19 - Address bit seven is direction, not control
// RQ20 - Sequence wraps to zero after maximum
`default_nettype none
module rpds_top #(
  parameter logic [7:0] SUPPORTED_TYPES = 8'h0f
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic CE,
  input wire logic DESC_WR,
  input wire logic DESC_RD,
  input wire logic [4:0] DESC_ADDR,
  input wire logic [7:0] DESC_WDATA,
  output logic [7:0] DESC_RDATA,
  output logic DESC_RVALID,
  input wire logic DATA_SENT,
  input wire logic ACK_VALID,
  input wire logic [4:0] ACK_SEQ,
  input wire logic TXN_OK,
  input wire logic TXN_ERR,
  input wire logic BEACON_ADJ_VALID,
  input wire logic [7:0] BEACON_ADJ,
  input wire logic DN_RX,
  input wire logic [7:0] DN_SRC,
  output logic [7:0] SEQ_OUT,
  output logic [31:0] WINDOW_OUT,
  output logic [1:0] XFER_TYPE,
  output logic [2:0] TX_POWER,
  output logic [2:0] PREAMBLE_POLICY,
  output logic [7:0] POLL_INTERVAL,
  output logic [7:0] SERVICE_INTERVAL,
  output logic [3:0] EP_NUMBER,
  output logic EP_DIR_IN,
  output logic LOW_POWER_INT,
  output logic RETRY_TXN,
  output logic FAIL_XFER,
  output logic NOTIFY_VALID,
  output logic [7:0] NOTIFY_TYPE,
  output logic [7:0] NOTIFY_DATA
);
  logic [7:0] ep_addr_r;
  logic [7:0] seq_r;
  logic [7:0] seq_nxt;
  logic [31:0] win_r;
  logic [31:0] win_nxt;
  logic [7:0] maxseq_r;
  logic [7:0] intv_r;
  logic [7:0] air_r;
  logic [7:0] attr_r;
  logic [7:0] retry_opt_r;
  logic [15:0] err_r;
  logic [15:0] err_nxt;
  logic [7:0] poll_r;
  logic [7:0] rdata_r;
  logic rvalid_r;
  logic [7:0] rd_byte;
  logic [7:0] adj_prev_r;
  logic pend_dn_r;
  logic [7:0] dn_src_r;
  logic ntf_valid_r;
  logic [7:0] ntf_type_r;
  logic [7:0] ntf_data_r;
  logic win_hit;
  logic err_hit;
  logic seq_wr;
  logic bcn_chg;
  logic dn_sent;
  rpds_pkg::rpds_xfer_e xfer;

  rpds_retry_if rif();

  function automatic logic wr_at(input logic we, input logic [4:0] a, input logic [4:0] ofs);
    return we && (a == ofs);
  endfunction
  function automatic logic [31:0] put_byte(input logic [31:0] cur, input logic [1:0] lane,
                                           input logic [7:0] b);
    logic [31:0] v;
    v = cur;
    v[{lane, 3'h0} +: 8] = b;
    return v;
  endfunction
  function automatic logic [7:0] next_seq(input logic [7:0] s, input logic [7:0] mx);
    return (s >= mx) ? 8'h00 : 8'(s + 8'h01);
  endfunction

  assign win_hit = DESC_WR && (DESC_ADDR[4:2] == rpds_pkg::OFS_WIN[4:2]);
  assign err_hit = DESC_WR && (DESC_ADDR[4:1] == rpds_pkg::OFS_ERR[4:1]);
  assign seq_wr = wr_at(DESC_WR, DESC_ADDR, rpds_pkg::OFS_SEQ);
  assign xfer = rpds_pkg::rpds_xfer_e'(attr_r[rpds_pkg::ATTR_TYPE_LSB +: 2]); // [RQ7]

  // Plain host-writable fields
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ep_addr_r <= rpds_pkg::RST_BYTE;
      intv_r <= rpds_pkg::RST_BYTE;
      air_r <= rpds_pkg::RST_BYTE;
      attr_r <= rpds_pkg::RST_BYTE;
      retry_opt_r <= rpds_pkg::RST_BYTE;
    end else if (CE) begin
      if (wr_at(DESC_WR, DESC_ADDR, rpds_pkg::OFS_EP_ADDR)) begin
        ep_addr_r <= DESC_WDATA & rpds_pkg::EP_ADDR_MASK; // [RQ17]
      end
      if (wr_at(DESC_WR, DESC_ADDR, rpds_pkg::OFS_INTV)) begin
        intv_r <= DESC_WDATA; // [RQ17]
      end
      if (wr_at(DESC_WR, DESC_ADDR, rpds_pkg::OFS_AIR)) begin
        air_r <= DESC_WDATA; // [RQ17] [RQ6]
      end
      if (wr_at(DESC_WR, DESC_ADDR, rpds_pkg::OFS_ATTR)) begin
        attr_r <= DESC_WDATA; // [RQ17]
      end
      if (wr_at(DESC_WR, DESC_ADDR, rpds_pkg::OFS_RETRY)) begin
        retry_opt_r <= DESC_WDATA & rpds_pkg::RETRY_MASK; // [RQ17] [RQ13]
      end
    end
  end

  // Maximum sequence: illegal values are refused
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      maxseq_r <= rpds_pkg::RST_MAXSEQ;
    end else if (CE) begin
      if (wr_at(DESC_WR, DESC_ADDR, rpds_pkg::OFS_MAXSEQ) &&
          DESC_WDATA >= rpds_pkg::SEQ_MAX_LO && DESC_WDATA <= rpds_pkg::SEQ_MAX_HI) begin
        maxseq_r <= DESC_WDATA; // [RQ3]
      end
    end
  end

  // Next sequence: host write wins over a send
  always_comb begin
    seq_nxt = seq_r;
    if (seq_wr) begin
      seq_nxt = DESC_WDATA; // [RQ17]
    end else if (DATA_SENT) begin
      seq_nxt = next_seq(seq_r, maxseq_r); // [RQ1] [RQ20]
    end
  end
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      seq_r <= rpds_pkg::RST_BYTE;
    end else if (CE) begin
      seq_r <= seq_nxt;
    end
  end

  // Window: sent marks a bit, ack clears it; set wins
  always_comb begin
    win_nxt = win_r;
    if (win_hit) begin
      win_nxt = put_byte(win_r, DESC_ADDR[1:0], DESC_WDATA); // [RQ17]
    end
    if (ACK_VALID) begin
      win_nxt[ACK_SEQ] = 1'b0; // [RQ2]
    end
    if (DATA_SENT) begin
      win_nxt[seq_r[4:0]] = 1'b1; // [RQ2]
    end
  end
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      win_r <= rpds_pkg::RST_WIN;
    end else if (CE) begin
      win_r <= win_nxt;
    end
  end

  // Error counter: hardware increment lands on top of a write
  always_comb begin
    err_nxt = err_r;
    if (err_hit) begin
      err_nxt = 16'(put_byte({16'h0000, err_r}, {1'b0, DESC_ADDR[0]}, DESC_WDATA)); // [RQ16]
    end
    if (TXN_ERR) begin
      err_nxt = 16'(err_nxt + 16'h0001); // [RQ15]
    end
  end
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      err_r <= rpds_pkg::RST_ERR;
    end else if (CE) begin
      err_r <= err_nxt;
    end
  end

  // Effective polling interval
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      poll_r <= rpds_pkg::RST_BYTE;
    end else if (CE) begin
      poll_r <= (xfer == rpds_pkg::XFER_ISO) ? air_r : intv_r; // [RQ4] [RQ5]
    end
  end

  // Read multiplexer, unmapped offsets read zero
  always_comb begin
    rd_byte = 8'h00;
    if (DESC_ADDR[4:2] == rpds_pkg::OFS_WIN[4:2]) begin
      rd_byte = win_r[{DESC_ADDR[1:0], 3'h0} +: 8];
    end else if (DESC_ADDR[4:1] == rpds_pkg::OFS_ERR[4:1]) begin
      rd_byte = DESC_ADDR[0] ? err_r[15:8] : err_r[7:0];
    end else begin
      case (DESC_ADDR)
        rpds_pkg::OFS_EP_ADDR: rd_byte = ep_addr_r;
        rpds_pkg::OFS_SEQ: rd_byte = seq_r;
        rpds_pkg::OFS_MAXSEQ: rd_byte = maxseq_r;
        rpds_pkg::OFS_INTV: rd_byte = intv_r;
        rpds_pkg::OFS_AIR: rd_byte = air_r;
        rpds_pkg::OFS_ATTR: rd_byte = attr_r;
        rpds_pkg::OFS_CHAR: rd_byte = SUPPORTED_TYPES & rpds_pkg::CHAR_MASK; // [RQ10]
        rpds_pkg::OFS_RETRY: rd_byte = retry_opt_r;
        default: rd_byte = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_r <= rpds_pkg::RST_BYTE;
      rvalid_r <= 1'b0;
    end else if (CE) begin
      rvalid_r <= DESC_RD;
      if (DESC_RD) begin
        rdata_r <= rd_byte;
      end
    end
  end

  // Notifications: adjust change first, device notice waits
  assign bcn_chg = BEACON_ADJ_VALID && (BEACON_ADJ != adj_prev_r);
  assign dn_sent = pend_dn_r && !bcn_chg;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      adj_prev_r <= rpds_pkg::RST_BYTE;
      pend_dn_r <= 1'b0;
      dn_src_r <= rpds_pkg::RST_BYTE;
    end else if (CE) begin
      if (BEACON_ADJ_VALID) begin
        adj_prev_r <= BEACON_ADJ;
      end
      pend_dn_r <= (pend_dn_r && !dn_sent) || DN_RX; // [RQ18]
      if (DN_RX) begin
        dn_src_r <= DN_SRC;
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ntf_valid_r <= 1'b0;
      ntf_type_r <= rpds_pkg::RST_BYTE;
      ntf_data_r <= rpds_pkg::RST_BYTE;
    end else if (CE) begin
      ntf_valid_r <= bcn_chg || dn_sent;
      if (bcn_chg) begin
        ntf_type_r <= rpds_pkg::NOTIFY_BEACON; // [RQ18]
        ntf_data_r <= BEACON_ADJ;
      end else if (dn_sent) begin
        ntf_type_r <= rpds_pkg::NOTIFY_DN; // [RQ18]
        ntf_data_r <= dn_src_r;
      end
    end
  end

  // Retry tracker
  assign rif.txn_ok = TXN_OK;
  assign rif.txn_err = TXN_ERR;
  assign rif.low_power = retry_opt_r[rpds_pkg::RETRY_LP_BIT]; // [RQ14]
  assign rif.limit = retry_opt_r[3:0]; // [RQ11]

  rpds_retry u_retry (
    .clk(CLK),
    .arst_n(ARST_N),
    .ce(CE),
    .rif(rif.eng)
  );

  // Outputs
  assign DESC_RDATA = rdata_r;
  assign DESC_RVALID = rvalid_r;
  assign SEQ_OUT = seq_r; // [RQ1]
  assign WINDOW_OUT = win_r;
  assign XFER_TYPE = xfer;
  assign TX_POWER = attr_r[rpds_pkg::ATTR_PWR_LSB +: 3]; // [RQ8]
  assign PREAMBLE_POLICY = attr_r[rpds_pkg::ATTR_PRE_LSB +: 3]; // [RQ9]
  assign POLL_INTERVAL = poll_r;
  assign SERVICE_INTERVAL = intv_r; // [RQ4]
  assign EP_NUMBER = ep_addr_r[3:0];
  assign EP_DIR_IN = (xfer != rpds_pkg::XFER_CTRL) && ep_addr_r[rpds_pkg::EP_DIR_BIT]; // [RQ19]
  assign LOW_POWER_INT = rif.low_power;
  assign RETRY_TXN = rif.retry;
  assign FAIL_XFER = rif.fail;
  assign NOTIFY_VALID = ntf_valid_r;
  assign NOTIFY_TYPE = ntf_type_r;
  assign NOTIFY_DATA = ntf_data_r;

  property p_seq_wrap;
    @(posedge CLK) disable iff (!ARST_N)
    CE && DATA_SENT && !seq_wr && (seq_r >= maxseq_r) |=> SEQ_OUT == 8'h00;
  endproperty
  a_seq_wrap: assert property (p_seq_wrap) else $error("sequence did not wrap"); // [RQ20]
  property p_seq_step;
    @(posedge CLK) disable iff (!ARST_N)
    CE && DATA_SENT && !seq_wr && (seq_r < maxseq_r) |=> SEQ_OUT == 8'($past(seq_r) + 8'h01);
  endproperty
  a_seq_step: assert property (p_seq_step) else $error("sequence did not step"); // [RQ1]
  property p_maxseq_legal;
    @(posedge CLK) disable iff (!ARST_N)
    maxseq_r >= rpds_pkg::SEQ_MAX_LO && maxseq_r <= rpds_pkg::SEQ_MAX_HI;
  endproperty
  a_maxseq_legal: assert property (p_maxseq_legal) else $error("maximum sequence illegal"); // [RQ3]
  property p_win_mark;
    @(posedge CLK) disable iff (!ARST_N)
    CE && DATA_SENT |=> WINDOW_OUT != 32'h0000_0000;
  endproperty
  a_win_mark: assert property (p_win_mark) else $error("window not marked"); // [RQ2]
  property p_err_inc;
    @(posedge CLK) disable iff (!ARST_N)
    CE && TXN_ERR && !err_hit |=> err_r == 16'($past(err_r) + 16'h0001);
  endproperty
  a_err_inc: assert property (p_err_inc) else $error("error count not bumped"); // [RQ15]
  property p_poll_iso;
    @(posedge CLK) disable iff (!ARST_N)
    CE && (xfer == rpds_pkg::XFER_ISO) |=> POLL_INTERVAL == $past(air_r);
  endproperty
  a_poll_iso: assert property (p_poll_iso) else $error("iso poll interval wrong"); // [RQ5]
  property p_char_ro;
    @(posedge CLK) disable iff (!ARST_N)
    CE && DESC_RD && DESC_ADDR == rpds_pkg::OFS_CHAR |=>
      DESC_RVALID && DESC_RDATA == (SUPPORTED_TYPES & rpds_pkg::CHAR_MASK);
  endproperty
  a_char_ro: assert property (p_char_ro) else $error("capability byte wrong"); // [RQ10]
  property p_bcn_ntf;
    @(posedge CLK) disable iff (!ARST_N)
    CE && bcn_chg |=> NOTIFY_VALID && NOTIFY_TYPE == rpds_pkg::NOTIFY_BEACON;
  endproperty
  a_bcn_ntf: assert property (p_bcn_ntf) else $error("adjust change not notified"); // [RQ18]
  property p_dir_ctrl;
    @(posedge CLK) disable iff (!ARST_N)
    CE && wr_at(DESC_WR, DESC_ADDR, rpds_pkg::OFS_EP_ADDR) |=>
      EP_DIR_IN == ($past(DESC_WDATA[rpds_pkg::EP_DIR_BIT]) && (XFER_TYPE != rpds_pkg::XFER_CTRL));
  endproperty
  a_dir_ctrl: assert property (p_dir_ctrl) else $error("direction on control pipe"); // [RQ19]
endmodule
`default_nettype wire

// ==== design/rpds_pkg.sv ====
// Constants and types for the remote pipe descriptor state block
`default_nettype none
package rpds_pkg;
  localparam int ADDR_W = 5;
  // Descriptor byte offsets
  localparam logic [4:0] OFS_EP_ADDR = 5'h0e;
  localparam logic [4:0] OFS_SEQ = 5'h0f;
  localparam logic [4:0] OFS_WIN = 5'h10;
  localparam logic [4:0] OFS_MAXSEQ = 5'h14;
  localparam logic [4:0] OFS_INTV = 5'h15;
  localparam logic [4:0] OFS_AIR = 5'h16;
  localparam logic [4:0] OFS_ATTR = 5'h17;
  localparam logic [4:0] OFS_CHAR = 5'h18;
  localparam logic [4:0] OFS_RETRY = 5'h19;
  localparam logic [4:0] OFS_ERR = 5'h1a;
  // Field positions and masks
  localparam int ATTR_TYPE_LSB = 0;
  localparam int ATTR_PWR_LSB = 2;
  localparam int ATTR_PRE_LSB = 5;
  localparam int RETRY_LP_BIT = 7;
  localparam int EP_DIR_BIT = 7;
  localparam logic [7:0] EP_ADDR_MASK = 8'h8f;
  localparam logic [7:0] CHAR_MASK = 8'h0f;
  localparam logic [7:0] RETRY_MASK = 8'h8f;
  localparam logic [7:0] SEQ_MAX_LO = 8'h01;
  localparam logic [7:0] SEQ_MAX_HI = 8'h1f;
  // Notification type codes
  localparam logic [7:0] NOTIFY_BEACON = 8'h94;
  localparam logic [7:0] NOTIFY_DN = 8'h95;
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_MAXSEQ = 8'h1f;
  localparam logic [31:0] RST_WIN = 32'h0000_0000;
  localparam logic [15:0] RST_ERR = 16'h0000;
  typedef enum logic [1:0] {
    XFER_CTRL = 2'h0,
    XFER_ISO = 2'h1,
    XFER_BULK = 2'h2,
    XFER_INTR = 2'h3
  } rpds_xfer_e;
endpackage
`default_nettype wire

// ==== design/rpds_retry_if.sv ====
// Signals between descriptor state and the retry tracker
`default_nettype none
interface rpds_retry_if;
  logic txn_ok;
  logic txn_err;
  logic low_power;
  logic [3:0] limit;
  logic retry;
  logic fail;
  logic [3:0] tries;
  modport ctl(output txn_ok, output txn_err, output low_power, output limit,
              input retry, input fail, input tries);
  modport eng(input txn_ok, input txn_err, input low_power, input limit,
              output retry, output fail, output tries);
endinterface
`default_nettype wire

// ==== design/rpds_retry.sv ====
// Retry tracker for one pipe's failing transactions
`default_nettype none
module rpds_retry (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  rpds_retry_if.eng rif
);
  logic [3:0] tries_r;
  logic retry_r;
  logic fail_r;
  logic counted;
  logic at_limit;

  assign counted = !rif.low_power && (rif.limit != 4'h0);
  assign at_limit = counted && (tries_r >= rif.limit);
  assign rif.retry = retry_r;
  assign rif.fail = fail_r;
  assign rif.tries = tries_r;

  // Count of retries spent on the current transaction
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tries_r <= 4'h0;
    end else if (ce) begin
      if (rif.txn_ok || (rif.txn_err && (at_limit || !counted))) begin
        tries_r <= 4'h0; // [RQ12] [RQ14]
      end else if (rif.txn_err) begin
        tries_r <= 4'(tries_r + 4'h1); // [RQ11]
      end
    end
  end

  // Retry or fail verdict, one cycle after the error
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      retry_r <= 1'b0;
      fail_r <= 1'b0;
    end else if (ce) begin
      retry_r <= rif.txn_err && !at_limit; // [RQ11] [RQ12]
      fail_r <= rif.txn_err && at_limit; // [RQ11]
    end
  end

  property p_fail_at_limit;
    @(posedge clk) disable iff (!arst_n)
    ce && rif.txn_err && at_limit |=> fail_r && !retry_r && tries_r == 4'h0;
  endproperty
  a_fail_at_limit: assert property (p_fail_at_limit) else $error("no fail at limit"); // [RQ11]

  property p_unlimited;
    @(posedge clk) disable iff (!arst_n)
    ce && rif.txn_err && (rif.limit == 4'h0) |=> retry_r && !fail_r;
  endproperty
  a_unlimited: assert property (p_unlimited) else $error("limit zero failed"); // [RQ12]

  property p_low_power;
    @(posedge clk) disable iff (!arst_n)
    ce && rif.txn_err && rif.low_power |=> !fail_r;
  endproperty
  a_low_power: assert property (p_low_power) else $error("low power pipe failed"); // [RQ14]
endmodule
`default_nettype wire

// ==== tb/rpds_host.sv ====
// Host software model issuing descriptor byte requests
`default_nettype none
module rpds_host (
  input wire logic clk,
  output logic desc_wr,
  output logic desc_rd,
  output logic [4:0] desc_addr,
  output logic [7:0] desc_wdata,
  input wire logic [7:0] desc_rdata,
  input wire logic desc_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    desc_wr = 1'b0;
    desc_rd = 1'b0;
    desc_addr = 5'h00;
    desc_wdata = 8'h00;
  end
  // Released lines show the inverse of the last value
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    desc_wr = 1'b1;
    desc_addr = a;
    desc_wdata = d;
    @(negedge clk);
    desc_wr = 1'b0;
    desc_addr = ~a;
    desc_wdata = ~d;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d, output logic v);
    @(negedge clk);
    desc_rd = 1'b1;
    desc_addr = a;
    @(negedge clk);
    d = desc_rdata;
    v = desc_rvalid;
    desc_rd = 1'b0;
    desc_addr = ~a;
  endtask
  // Pipe type set-up with the host's own obligations
  task automatic set_type(input logic [1:0] t, input logic [7:0] air, input logic [3:0] lim);
    wr(rpds_pkg::OFS_ATTR, {3'h5, 3'h2, t});
    wr(rpds_pkg::OFS_AIR, (t == rpds_pkg::XFER_ISO) ? air : 8'h00);
    wr(rpds_pkg::OFS_RETRY, (t == rpds_pkg::XFER_ISO) ? 8'h00 : {4'h0, lim});
  endtask
  task automatic clear_err();
    wr(rpds_pkg::OFS_ERR, 8'h00);
    wr(5'h1b, 8'h00);
  endtask
endmodule
`default_nettype wire

// ==== tb/rpds_top_bench.sv ====
// Self-checking bench for the descriptor state block
`default_nettype none
module rpds_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [4:0] a; logic [7:0] d; logic [7:0] e;} rpds_row_s;
  localparam rpds_row_s ROWS [18] = '{
    '{5'h0f, 8'h07, 8'h07}, '{5'h10, 8'h78, 8'h78}, '{5'h11, 8'h56, 8'h56}, '{5'h12, 8'h34, 8'h34},
    '{5'h13, 8'h12, 8'h12}, '{5'h14, 8'h00, 8'h1f}, '{5'h14, 8'h20, 8'h1f}, '{5'h14, 8'h01, 8'h01},
    '{5'h14, 8'h1f, 8'h1f}, '{5'h15, 8'h08, 8'h08}, '{5'h16, 8'h04, 8'h04}, '{5'h17, 8'h25, 8'h25},
    '{5'h18, 8'haa, 8'h0f}, '{5'h19, 8'hff, 8'h8f}, '{5'h0e, 8'hff, 8'h8f}, '{5'h1c, 8'h55, 8'h00},
    '{5'h1a, 8'h34, 8'h34}, '{5'h1b, 8'h12, 8'h12}};
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic ce = 1'b1;
  logic wr, rd, rvalid, data_sent, ack_valid, txn_ok, txn_err, bcn_v, dn_rx;
  logic [4:0] addr;
  logic [4:0] ack_seq = 5'h00;
  logic [7:0] wdata, rdata, seq_out, poll, serv, ntype, ndata;
  logic [7:0] adj = 8'h00;
  logic [7:0] dn_src = 8'h00;
  logic [31:0] win;
  logic [1:0] xtype;
  logic [2:0] pwr, pre;
  logic [3:0] ep_num;
  logic ep_in, lp_int, retry, fail, nvalid;
  int err_total = 0;
  int checked = 0;
  initial begin
    {data_sent, ack_valid, txn_ok, txn_err} = 4'h0;
    {bcn_v, dn_rx} = 2'h0;
  end
  always #5 clk = ~clk;
  rpds_host u_rpds_host (.clk(clk), .desc_wr(wr), .desc_rd(rd), .desc_addr(addr), .desc_wdata(wdata),
    .desc_rdata(rdata), .desc_rvalid(rvalid));
  rpds_top u_rpds_top (.CLK(clk), .ARST_N(arst_n), .CE(ce), .DESC_WR(wr), .DESC_RD(rd), .DESC_ADDR(addr),
    .DESC_WDATA(wdata), .DESC_RDATA(rdata), .DESC_RVALID(rvalid), .DATA_SENT(data_sent),
    .ACK_VALID(ack_valid), .ACK_SEQ(ack_seq), .TXN_OK(txn_ok), .TXN_ERR(txn_err), .BEACON_ADJ_VALID(bcn_v),
    .BEACON_ADJ(adj), .DN_RX(dn_rx), .DN_SRC(dn_src), .SEQ_OUT(seq_out), .WINDOW_OUT(win), .XFER_TYPE(xtype),
    .TX_POWER(pwr), .PREAMBLE_POLICY(pre), .POLL_INTERVAL(poll), .SERVICE_INTERVAL(serv), .EP_NUMBER(ep_num),
    .EP_DIR_IN(ep_in), .LOW_POWER_INT(lp_int), .RETRY_TXN(retry), .FAIL_XFER(fail), .NOTIFY_VALID(nvalid),
    .NOTIFY_TYPE(ntype), .NOTIFY_DATA(ndata));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    u_rpds_host.rd(a, d, v);
    chk("rvalid", 32'h1, {31'h0, v});
    chk("rdata", {24'h0, e}, {24'h0, d});
  endtask
  task automatic do_reset();
    @(negedge clk);
    arst_n = 1'b0;
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
  endtask
  // One-cycle engine event: sent, ack, ok, error
  task automatic ev(input logic [3:0] s);
    @(negedge clk);
    {data_sent, ack_valid, txn_ok, txn_err} = s;
    @(negedge clk);
    {data_sent, ack_valid, txn_ok, txn_err} = 4'h0;
  endtask
  task automatic nt(input logic b, input logic [7:0] v, input logic d, input logic [7:0] s);
    @(negedge clk);
    {bcn_v, dn_rx} = {b, d};
    adj = v;
    dn_src = s;
    @(negedge clk);
    {bcn_v, dn_rx} = 2'h0;
  endtask
  task automatic final_report();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    do_reset();
    chk("seq_out", 32'h0, {24'h0, seq_out});
    chk("notify_valid", 32'h0, {31'h0, nvalid});
    foreach (ROWS[i]) begin
      u_rpds_host.wr(ROWS[i].a, ROWS[i].d);
      rd_chk(ROWS[i].a, ROWS[i].e);
    end
    chk("window", 32'h12345678, win);
    chk("type", 32'h1, {30'h0, xtype});
    chk("power", 32'h1, {29'h0, pwr});
    chk("preamble", 32'h1, {29'h0, pre});
    // Sequence wrap and window bits
    for (int i = 0; i < 4; i++) u_rpds_host.wr(5'h10 + 5'(i), 8'h00);
    u_rpds_host.wr(rpds_pkg::OFS_MAXSEQ, 8'h02);
    u_rpds_host.wr(rpds_pkg::OFS_SEQ, 8'h02);
    ev(4'h8);
    chk("seq_out", 32'h0, {24'h0, seq_out});
    chk("window", 32'h4, win);
    ev(4'h8);
    chk("seq_out", 32'h1, {24'h0, seq_out});
    chk("window", 32'h5, win);
    ack_seq = 5'h02;
    ev(4'h4);
    chk("window", 32'h1, win);
    rd_chk(rpds_pkg::OFS_SEQ, 8'h01);
    @(negedge clk);
    ce = 1'b0;
    ev(4'h8);
    chk("seq_out", 32'h1, {24'h0, seq_out});
    ce = 1'b1;
    // Attribute decode for every transfer type
    u_rpds_host.wr(rpds_pkg::OFS_EP_ADDR, 8'h83);
    u_rpds_host.wr(rpds_pkg::OFS_INTV, 8'h08);
    for (int t = 0; t < 4; t++) begin
      u_rpds_host.set_type(2'(t), 8'h04, 4'h1);
      @(negedge clk);
      chk("type", t, {30'h0, xtype});
      chk("power", 32'h2, {29'h0, pwr});
      chk("preamble", 32'h5, {29'h0, pre});
      chk("poll", (t == 1) ? 32'h4 : 32'h8, {24'h0, poll});
      chk("service", 32'h8, {24'h0, serv});
      chk("ep_in", (t != 0) ? 32'h1 : 32'h0, {31'h0, ep_in});
      chk("ep_num", 32'h3, {28'h0, ep_num});
    end
    // Retry limit one, then unlimited, then low power
    u_rpds_host.clear_err();
    ev(4'h1);
    chk("retry", 32'h1, {30'h0, fail, retry});
    ev(4'h1);
    chk("fail", 32'h2, {30'h0, fail, retry});
    rd_chk(rpds_pkg::OFS_ERR, 8'h02);
    u_rpds_host.wr(rpds_pkg::OFS_RETRY, 8'h00);
    repeat (3) begin
      ev(4'h1);
      chk("retry", 32'h1, {30'h0, fail, retry});
    end
    u_rpds_host.wr(rpds_pkg::OFS_RETRY, 8'h81);
    chk("low_power", 32'h1, {31'h0, lp_int});
    repeat (3) begin
      ev(4'h1);
      chk("fail", 32'h0, {31'h0, fail});
    end
    u_rpds_host.wr(rpds_pkg::OFS_ERR, 8'hff);
    u_rpds_host.wr(5'h1b, 8'h00);
    ev(4'h1);
    rd_chk(5'h1b, 8'h01);
    rd_chk(rpds_pkg::OFS_ERR, 8'h00);
    // Notifications
    nt(1'b1, 8'h05, 1'b0, 8'h00);
    chk("notify", {24'h1, rpds_pkg::NOTIFY_BEACON}, {23'h0, nvalid, ntype});
    chk("notify_data", 32'h5, {24'h0, ndata});
    nt(1'b1, 8'h05, 1'b0, 8'h00);
    chk("notify_valid", 32'h0, {31'h0, nvalid});
    nt(1'b0, 8'h00, 1'b1, 8'h42);
    // Device notice is held pending one cycle first
    @(negedge clk);
    chk("notify", {24'h1, rpds_pkg::NOTIFY_DN}, {23'h0, nvalid, ntype});
    chk("notify_data", 32'h42, {24'h0, ndata});
    // Second reset in mid-run
    do_reset();
    chk("seq_out", 32'h0, {24'h0, seq_out});
    chk("window", 32'h0, win);
    rd_chk(rpds_pkg::OFS_MAXSEQ, 8'h1f);
    rd_chk(rpds_pkg::OFS_RETRY, 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
